/* core/fsh_params.svh */
// Constants shared by the shifter-slice host controller.
// Assumes inclusion by the package and by the design modules.
`ifndef FSH_PARAMS_SVH
`define FSH_PARAMS_SVH

// =====================================================================
// Geometry of the slice array
`define FSH_WORD_W   16
`define FSH_SLICE_W  4
`define FSH_LINK_W   3
`define FSH_SEL_W    2
`define FSH_AMT_W    3
`define FSH_BANKS    2

// =====================================================================
// Pin levels and encodings
`define FSH_OE_OFF   1'b1
`define FSH_BIT_LO   1'b0
`define FSH_ST_IDLE  2'h0
`define FSH_ST_DRIVE 2'h1
`define FSH_ST_DONE  2'h3
`define FSH_MD_ZERO  2'h0
`define FSH_MD_SIGN  2'h1
`define FSH_MD_ROT   2'h2

`endif

/* core/fsh_pkg.sv */
// Types for the shifter-slice host controller.
// Assumes fsh_params.svh is on the include path.
`include "fsh_params.svh"

package fsh_pkg;

   // =====================================================================
   // Enumerations
   typedef enum logic [1:0] {
      FSH_MODE_ZERO = `FSH_MD_ZERO,
      FSH_MODE_SIGN = `FSH_MD_SIGN,
      FSH_MODE_ROT  = `FSH_MD_ROT
   } fsh_mode_t;

   // Gray codes along idle -> drive -> done
   typedef enum logic [1:0] {
      FSH_IDLE  = `FSH_ST_IDLE,
      FSH_DRIVE = `FSH_ST_DRIVE,
      FSH_DONE  = `FSH_ST_DONE
   } fsh_state_t;

   // =====================================================================
   // Request command carried with each word
   typedef struct packed {
      fsh_mode_t                mode;
      logic [`FSH_AMT_W-1:0]    amount;
   } fsh_req_t;

endpackage : fsh_pkg

/* core/fsh_bank_enable.sv */
// Output-enable decoder for paralleled slice banks.
// Assumes the caller registers the result before it reaches the pins.
`include "fsh_params.svh"

module fsh_bank_enable #(
   parameter int BANKS = `FSH_BANKS,
   parameter int IDX_W = `FSH_AMT_W - `FSH_SEL_W
) (
   input  wire logic             enable,     // Drive one bank this cycle
   input  wire logic [IDX_W-1:0] bank_idx,   // Bank holding the shift range
   output logic      [BANKS-1:0] oe_n        // Active-low enables, one per bank
);
   import fsh_pkg::*;

   // =====================================================================
   // One-hot-low decode
   genvar b;
   generate
      for (b = 0; b < BANKS; b++)
      begin : g_bank
         assign oe_n[b] = ~(enable && (bank_idx == IDX_W'(b)));
      end
   endgenerate

endmodule // fsh_bank_enable

/* core/fsh_host_ctrl.sv */
// Host controller driving banks of combinational 4-bit shifter slices.
// Assumes the paralleled slice outputs are resolved onto SHIFT_BUS
// within the same clock cycle that an output enable goes low.
//
// Behaviour
// - Cascade slices; each slice's links take the lower slice's top bits.
// - Paralleled banks; output enables act as a third select level.
// - Zero backfill holds the lowest slice's links low.
// - Sign extension reverses bit order, ties lowest links to bit zero.
// - Link wiring gives zero-backfill, sign-extend and rotate modes.
`include "fsh_params.svh"

module fsh_host_ctrl #(
   parameter int WIDTH = `FSH_WORD_W,
   parameter int BANKS = `FSH_BANKS
) (
   input  wire logic                                  SYS_CLK,             // 100 MHz clock
   input  wire logic                                  RST,                 // Async reset, high
   input  wire logic                                  REQ_VALID,           // Request offered
   output logic                                       REQ_READY,           // Idle, can accept
   input  wire fsh_pkg::fsh_req_t                     REQ_CMD,             // Mode and amount
   input  wire logic [WIDTH-1:0]                      REQ_DATA,            // Word to shift
   output logic                                       RSP_VALID,           // Result pulse
   output logic [WIDTH-1:0]                           RSP_DATA,            // Shifted word
   output logic [BANKS*WIDTH-1:0]                     SLICE_DATA,          // Slice data pins
   output logic [BANKS*(WIDTH/`FSH_SLICE_W)*`FSH_LINK_W-1:0] SLICE_LINK,   // Slice linking pins
   output logic                                       SHIFT_AMOUNT_SEL_LO, // Select bit 0
   output logic                                       SHIFT_AMOUNT_SEL_HI, // Select bit 1
   output logic [BANKS-1:0]                           SLICE_OE_N,          // Bank enables, low
   input  wire logic [WIDTH-1:0]                      SHIFT_BUS            // Resolved outputs
);
   import fsh_pkg::*;

   localparam int SLICES = WIDTH / `FSH_SLICE_W;
   localparam int LINKS  = SLICES * `FSH_LINK_W;
   localparam int IDX_W  = `FSH_AMT_W - `FSH_SEL_W;

   // =====================================================================
   // Helpers
   function automatic logic [WIDTH-1:0] bit_rev(input logic [WIDTH-1:0] w);
      logic [WIDTH-1:0] r;
      r = '0;
      for (int i = 0; i < WIDTH; i++)
         r[i] = w[WIDTH-1-i];
      return r;
   endfunction

   // Value at a possibly negative position of the prepared word
   function automatic logic fill_bit(input logic [WIDTH-1:0] w, input int pos, input fsh_mode_t m);
      int idx;
      idx = ((pos % WIDTH) + WIDTH) % WIDTH;
      if (pos >= 0)
         return w[idx];
      unique case (m)
         FSH_MODE_ROT:  return w[idx];
         FSH_MODE_SIGN: return w[0];
         default:       return `FSH_BIT_LO;
      endcase
   endfunction

   // =====================================================================
   // Declarations
   fsh_state_t             state_ff;
   fsh_state_t             nxt_state;
   fsh_mode_t              mode_ff;
   logic [`FSH_AMT_W-1:0]  amt_ff;
   logic [BANKS*WIDTH-1:0] data_ff;
   logic [BANKS*WIDTH-1:0] nxt_data;
   logic [BANKS*LINKS-1:0] link_ff;
   logic [BANKS*LINKS-1:0] nxt_link;
   logic [BANKS-1:0]       oe_n_ff;
   logic [BANKS-1:0]       nxt_oe_n;
   logic                   rsp_valid_ff;
   logic [WIDTH-1:0]       rsp_data_ff;
   logic [WIDTH-1:0]       word_in;
   logic                   accept;

   assign REQ_READY           = (state_ff == FSH_IDLE);
   assign accept              = REQ_VALID && REQ_READY;
   assign RSP_VALID           = rsp_valid_ff;
   assign RSP_DATA            = rsp_data_ff;
   assign SLICE_DATA          = data_ff;
   assign SLICE_LINK          = link_ff;
   assign SLICE_OE_N          = oe_n_ff;
   assign SHIFT_AMOUNT_SEL_LO = amt_ff[0];
   assign SHIFT_AMOUNT_SEL_HI = amt_ff[1];

   // =====================================================================
   // Pin pattern for every bank and slice
   // reverse for sign extension
   assign word_in = (REQ_CMD.mode == FSH_MODE_SIGN) ? bit_rev(REQ_DATA) : REQ_DATA;

   always_comb
   begin
      nxt_data = '0;
      nxt_link = '0;
      for (int b = 0; b < BANKS; b++)
      begin
         // bank b pre-shifted by four places per bank
         for (int j = 0; j < WIDTH; j++)
            nxt_data[b*WIDTH + j] = fill_bit(word_in, j - b*`FSH_SLICE_W, REQ_CMD.mode);
         for (int k = 0; k < SLICES; k++)
         begin
            for (int m = 0; m < `FSH_LINK_W; m++)
            begin
               // cascade from lower slice; lowest slice by mode
               if (k == 0)
                  nxt_link[b*LINKS + m] = fill_bit(word_in, m - b*`FSH_SLICE_W - `FSH_LINK_W, REQ_CMD.mode);
               else
                  nxt_link[b*LINKS + k*`FSH_LINK_W + m] =
                     nxt_data[b*WIDTH + k*`FSH_SLICE_W - `FSH_LINK_W + m];
            end
         end
      end
   end

   // =====================================================================
   // Sequencer
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         FSH_IDLE:  if (accept) nxt_state = FSH_DRIVE;
         FSH_DRIVE: nxt_state = FSH_DONE;
         FSH_DONE:  nxt_state = FSH_IDLE;
         default:   nxt_state = FSH_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         state_ff <= FSH_IDLE;
      else
         state_ff <= nxt_state;
   end

   // Pins held from accept until the next request
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         mode_ff <= FSH_MODE_ZERO;
         amt_ff  <= '0;
         data_ff <= '0;
         link_ff <= '0;
      end
      else if (accept)
      begin
         mode_ff <= REQ_CMD.mode;
         amt_ff  <= REQ_CMD.amount;
         data_ff <= nxt_data;
         link_ff <= nxt_link;
      end
   end

   // =====================================================================
   // Bank enables: low for exactly the drive cycle
   fsh_bank_enable #(
      .BANKS (BANKS),
      .IDX_W (IDX_W)
   ) u_bank_enable (
      .enable   (accept),
      .bank_idx (REQ_CMD.amount[`FSH_AMT_W-1:`FSH_SEL_W]),
      .oe_n     (nxt_oe_n)
   );

   // registered so no bank glitches low
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         oe_n_ff <= {BANKS{`FSH_OE_OFF}};
      else
         oe_n_ff <= nxt_oe_n;
   end

   // =====================================================================
   // Result capture
   // bus settles within the drive cycle
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         rsp_valid_ff <= 1'b0;
         rsp_data_ff  <= '0;
      end
      else
      begin
         rsp_valid_ff <= (state_ff == FSH_DRIVE);
         if (state_ff == FSH_DRIVE)
            rsp_data_ff <= (mode_ff == FSH_MODE_SIGN) ? bit_rev(SHIFT_BUS) : SHIFT_BUS;
      end
   end

   // =====================================================================
   // Checks
   sequence s_accept;
      REQ_VALID && REQ_READY;
   endsequence

   sequence s_drive;
      (state_ff == FSH_DRIVE) && (SLICE_OE_N != {BANKS{`FSH_OE_OFF}});
   endsequence

   sequence s_answer;
      RSP_VALID && (state_ff == FSH_DONE);
   endsequence

   AST_ONE_BANK: assert property (@(posedge SYS_CLK) disable iff (RST)
      $onehot0(~SLICE_OE_N))
      else $error("More than one bank enable low");

   AST_TXN: assert property (@(posedge SYS_CLK) disable iff (RST)
      s_accept |=> s_drive ##1 s_answer)
      else $error("Drive and answer sequence broken");

   AST_OE_LEVEL: assert property (@(posedge SYS_CLK) disable iff (RST)
      (state_ff == FSH_DRIVE) |-> !SLICE_OE_N[amt_ff[`FSH_AMT_W-1:`FSH_SEL_W]])
      else $error("Wrong bank enabled for amount");

   AST_SEL: assert property (@(posedge SYS_CLK) disable iff (RST)
      s_accept |=> ({SHIFT_AMOUNT_SEL_HI, SHIFT_AMOUNT_SEL_LO} == $past(REQ_CMD.amount[`FSH_SEL_W-1:0])))
      else $error("Select pins disagree with amount");

   genvar gb, gk;
   generate
      for (gb = 0; gb < BANKS; gb++)
      begin : g_chk
         AST_ZERO_FILL: assert property (@(posedge SYS_CLK) disable iff (RST)
            (state_ff == FSH_DRIVE && mode_ff == FSH_MODE_ZERO) |->
               (SLICE_LINK[gb*LINKS +: `FSH_LINK_W] == '0))
            else $error("Zero backfill links not low");

         AST_SIGN_FILL: assert property (@(posedge SYS_CLK) disable iff (RST)
            (state_ff == FSH_DRIVE && mode_ff == FSH_MODE_SIGN) |->
               (SLICE_LINK[gb*LINKS +: `FSH_LINK_W] == {`FSH_LINK_W{SLICE_DATA[gb*WIDTH]}}))
            else $error("Sign links not tied to bit zero");

         AST_ROT_FILL: assert property (@(posedge SYS_CLK) disable iff (RST)
            (state_ff == FSH_DRIVE && mode_ff == FSH_MODE_ROT) |->
               (SLICE_LINK[gb*LINKS +: `FSH_LINK_W] == SLICE_DATA[gb*WIDTH + WIDTH - `FSH_LINK_W +: `FSH_LINK_W]))
            else $error("Rotate links not end-around");

         for (gk = 1; gk < SLICES; gk++)
         begin : g_slice
            AST_CASCADE: assert property (@(posedge SYS_CLK) disable iff (RST)
               (state_ff == FSH_DRIVE) |->
                  (SLICE_LINK[gb*LINKS + gk*`FSH_LINK_W +: `FSH_LINK_W] ==
                   SLICE_DATA[gb*WIDTH + gk*`FSH_SLICE_W - `FSH_LINK_W +: `FSH_LINK_W]))
               else $error("Cascade links not from lower slice");
         end
      end
   endgenerate

endmodule // fsh_host_ctrl

/* bench/fsh_slice_model.sv */
// Behavioural model of two banks of four 4-bit shifter slices.
// Assumes pins come from the host controller and SHIFT_BUS goes back to it.
module fsh_slice_model (
   input  wire logic        clk,    // Bench clock, remembers last bus value
   input  wire logic [31:0] data,   // Slice data pins, both banks
   input  wire logic [23:0] link,   // Slice linking pins, both banks
   input  wire logic        sel_lo, // Shift select bit 0
   input  wire logic        sel_hi, // Shift select bit 1
   input  wire logic [1:0]  oe_n,   // Bank enables, active low
   output logic      [15:0] bus     // Wired outputs of both banks
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] bank_out [2];
   logic [15:0] last_ff = 16'h0000;
   // ==========================================================
   // Slice function
   // shift up, links fill low places
   always_comb
   begin
      int pos;
      pos = 0;
      for (int b = 0; b < 2; b++)
         for (int k = 0; k < 4; k++)
            for (int j = 0; j < 4; j++)
            begin
               pos = j - int'({sel_hi, sel_lo});
               bank_out[b][k*4+j] = (pos >= 0) ? data[b*16+k*4+pos] : link[b*12+k*3+pos+3];
            end
   end
   // ==========================================================
   // Wired bus
   // enable high floats; no pull-up, so float shows inverted old value
   always_comb
   begin
      case (oe_n)
         2'b10:   bus = bank_out[0];
         2'b01:   bus = bank_out[1];
         2'b11:   bus = ~last_ff;
         default: bus = 'x;
      endcase
   end
   always @(posedge clk)
      if (oe_n != 2'b11)
         last_ff <= bus;
endmodule // fsh_slice_model

/* bench/test_fsh_host_ctrl.sv */
// Self-checking bench for the shifter-slice host controller.
// Assumes fsh_pkg is compiled first and the slice model stands at the pins.
module test_fsh_host_ctrl import fsh_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_ready, rsp_valid, sel_lo, sel_hi;
   fsh_req_t    req_cmd = '0;
   logic [15:0] req_data = 16'h0000, rsp_data, shift_bus;
   logic [31:0] slice_data;
   logic [23:0] slice_link;
   logic [1:0]  oe_n;
   int bad_count = 0, n_compared = 0;
   always #5 clk = ~clk;
   fsh_host_ctrl #(.WIDTH(16), .BANKS(2)) fsh_host_ctrl_i (.SYS_CLK(clk), .RST(rst), .REQ_VALID(req_valid),
      .REQ_READY(req_ready), .REQ_CMD(req_cmd), .REQ_DATA(req_data), .RSP_VALID(rsp_valid),
      .RSP_DATA(rsp_data), .SLICE_DATA(slice_data), .SLICE_LINK(slice_link), .SHIFT_AMOUNT_SEL_LO(sel_lo),
      .SHIFT_AMOUNT_SEL_HI(sel_hi), .SLICE_OE_N(oe_n), .SHIFT_BUS(shift_bus));
   fsh_slice_model fsh_slice_model_i (.clk(clk), .data(slice_data), .link(slice_link), .sel_lo(sel_lo),
      .sel_hi(sel_hi), .oe_n(oe_n), .bus(shift_bus));
   // ==========================================================
   // Shared tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      if (bad_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   function automatic logic [15:0] expect_shift(input logic [1:0] m, input logic [2:0] a, input logic [15:0] d);
      logic [31:0] tmp;
      tmp = {d, d} << a;
      case (m)
         2'h1:    return $signed(d) >>> a;
         2'h2:    return tmp[31:16];
         default: return d << a;
      endcase
   endfunction
   // One request, checked cycle by cycle; returns with REQ_READY high again
   task automatic do_shift(input logic [1:0] m, input logic [2:0] a, input logic [15:0] d);
      int n;
      n = 0;
      req_cmd.mode = fsh_mode_t'(m);
      req_cmd.amount = a;
      req_data = d;
      req_valid = 1'b1;
      while (req_ready !== 1'b1 && n < 20)
      begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      req_valid = 1'b0;
      check("ready_busy", req_ready, 1'b0);
      check("oe_c1", oe_n, a[2] ? 2'b01 : 2'b10);
      check("sel", {sel_hi, sel_lo}, a[1:0]);
      if (m != 2'h1)
      begin
         check("data0", slice_data[15:0], d);
         check("link1", slice_link[5:3], d[3:1]);
         check("link0", slice_link[2:0], (m == 2'h2) ? d[15:13] : 3'h0);
      end
      @(negedge clk);
      check("rsp_valid", rsp_valid, 1'b1);
      check("rsp_data", rsp_data, expect_shift(m, a, d));
      check("oe_c2", oe_n, 2'b11);
      check("sel_hold", {sel_hi, sel_lo}, a[1:0]);
      @(negedge clk);
      check("rsp_pulse", rsp_valid, 1'b0);
      check("ready_back", req_ready, 1'b1);
   endtask
   task automatic check_idle();
      check("idle_oe", oe_n, 2'b11);
      check("idle_valid", rsp_valid, 1'b0);
      check("idle_ready", req_ready, 1'b1);
   endtask
   // ==========================================================
   // Scenarios
   task automatic sweep_all();
      logic [15:0] words [3];
      words = '{16'hA5C3, 16'h8001, 16'h7FFE};
      // Back to back: each call starts on the edge the last one frees
      foreach (words[w])
         for (int m = 0; m < 4; m++)
            for (int a = 0; a < 8; a++)
               do_shift(m[1:0], a[2:0], words[w]);
   endtask
   task automatic reset_mid_run();
      req_cmd.mode = FSH_MODE_ROT;
      req_cmd.amount = 3'h5;
      req_data = 16'h1234;
      req_valid = 1'b1;
      @(negedge clk);
      req_valid = 1'b0;
      rst = 1'b1;
      #1;
      check_idle();
      @(negedge clk);
      rst = 1'b0;
      check_idle();
      do_shift(2'h0, 3'h7, 16'hFFFF);
   endtask
   initial
   begin
      repeat (4) @(negedge clk);
      check_idle();
      rst = 1'b0;
      @(negedge clk);
      check_idle();
      sweep_all();
      reset_mid_run();
      give_verdict();
   end
   // Sweep needs about 300 cycles; far beyond that means a hang
   initial
   begin
      repeat (5000) @(posedge clk);
      bad_count++;
      give_verdict();
   end
endmodule // test_fsh_host_ctrl
